// ---- tsr_params.svh ----
// Purpose: shared constants of the temperature read-out block
// Assumes: included by bare name by every design file that needs it
// Notes: offsets are the register pointer values seen over the serial bus
//
// Behaviour
// - flags sit in word bits 15 to 13
// - first byte flags at 0x80, 0x40, 0x20
// - positive value: bits 11..0 in sixteenths
// - negative value: two's complement, minus 256
// - high byte 16 and above, low byte below
// - fixed read-only maker code at pointer 6
// - flags: crit at/above, upper above, lower below
// - quarter degree default, two lowest bits zero
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

// ----------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------
`define TSR_PTR_TEMP 8'h05
`define TSR_PTR_MAKER 8'h06
`define TSR_PTR_RST 8'h00

// ----------------------------------------------------------------
// field positions of the ambient temperature word
// ----------------------------------------------------------------
`define TSR_BIT_CRIT 15
`define TSR_BIT_UPPER 14
`define TSR_BIT_LOWER 13
`define TSR_BIT_SIGN 12

// ----------------------------------------------------------------
// reset values and defaults
// ----------------------------------------------------------------
`define TSR_WORD_RST 16'h0000
`define TSR_SLAVE_ADDR 7'h18
// arbitrary neutral value, not a real maker code
`define TSR_MAKER_ID 16'h0A5C

`endif

// ---- tsr_pkg.sv ----
// Purpose: types of the temperature read-out block
// Assumes: nothing
// Notes: one-hot serial engine states
package tsr_pkg;

  typedef enum logic [6:0] {
    TSR_IDLE = 7'h01,
    TSR_ADDR = 7'h02,
    TSR_ACK_ADDR = 7'h04,
    TSR_RX_PTR = 7'h08,
    TSR_ACK_PTR = 7'h10,
    TSR_TX = 7'h20,
    TSR_TX_ACK = 7'h40
  } tsr_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    tsr_state_t state;
    logic [2:0] bit_cnt;
    logic got8;
    logic [7:0] shift;
    logic rw;
    logic [7:0] pointer;
    logic [15:0] tx_word;
    logic low_next;
    logic sda_oe_n;
    logic sda_out;
  } tsr_top_st_t;

  typedef struct packed {
    logic [15:0] word;
  } tsr_smp_st_t;

endpackage

// ---- tsr_word_if.sv ----
// Purpose: carries the live temperature word to the serial engine
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface tsr_word_if;
  logic [15:0] word;
  modport src (output word);
  modport snk (input word);
endinterface
`default_nettype wire

// ---- tsr_sample.sv ----
// Purpose: builds the ambient temperature word from converter results
// Assumes: conv inputs and limits come from logic on sys_clk
// Notes: limits are 13-bit two's complement, same scale as the word
`timescale 1ns/1ns
`default_nettype none
`include "tsr_params.svh"
module tsr_sample
  import tsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic conv_valid,
  input wire logic [12:0] conv_data,
  input wire logic [12:0] critical_limit,
  input wire logic [12:0] upper_limit,
  input wire logic [12:0] lower_limit,
  tsr_word_if.src wif
);

  tsr_smp_st_t st;
  tsr_smp_st_t next_st;
  logic [12:0] masked;

  always_comb begin
    next_st = st;
    masked = {conv_data[12:2], 2'b00};
    if (conv_valid) begin
      next_st.word[`TSR_BIT_CRIT] = $signed(masked) >= $signed(critical_limit);
      next_st.word[`TSR_BIT_UPPER] = $signed(masked) > $signed(upper_limit);
      next_st.word[`TSR_BIT_LOWER] = $signed(masked) < $signed(lower_limit);
      next_st.word[12:0] = masked;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '{word: `TSR_WORD_RST};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign wif.word = st.word;

  chk_flag_crit: assert property (@(posedge sys_clk) disable iff (srst)
    conv_valid && clk_en |=> st.word[15] ==
      ($signed({$past(conv_data[12:2]), 2'b00}) >= $signed($past(critical_limit))))
    else $error("critical flag wrong");
  chk_flag_upper: assert property (@(posedge sys_clk) disable iff (srst)
    conv_valid && clk_en |=> st.word[14] ==
      ($signed({$past(conv_data[12:2]), 2'b00}) > $signed($past(upper_limit))))
    else $error("upper flag wrong");
  chk_flag_lower: assert property (@(posedge sys_clk) disable iff (srst)
    conv_valid && clk_en |=> st.word[13] ==
      ($signed({$past(conv_data[12:2]), 2'b00}) < $signed($past(lower_limit))))
    else $error("lower flag wrong");
  chk_low_bits: assert property (@(posedge sys_clk) disable iff (srst)
    st.word[1:0] == 2'b00)
    else $error("low bits not zero");
  chk_value_bits: assert property (@(posedge sys_clk) disable iff (srst)
    conv_valid && clk_en |=> st.word[11:2] == $past(conv_data[11:2]))
    else $error("value bits wrong");
  chk_sign_bit: assert property (@(posedge sys_clk) disable iff (srst)
    conv_valid && clk_en |=> st.word[12] == $past(conv_data[12]))
    else $error("sign bit wrong");
  chk_word_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !(conv_valid && clk_en) |=> $stable(st.word))
    else $error("word changed without load");

endmodule // tsr_sample
`default_nettype wire

// ---- tsr_top.sv ----
// Purpose: serial-bus slave serving the temperature word and maker code
// Assumes: scl and sda are asynchronous pins; open-drain sda
// Notes: only one pointer byte per write; further bytes get no acknowledge
`timescale 1ns/1ns
`default_nettype none
`include "tsr_params.svh"
module tsr_top
  import tsr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = `TSR_SLAVE_ADDR,
  // arbitrary neutral value, not a real maker code
  parameter logic [15:0] MAKER_ID = `TSR_MAKER_ID
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic conv_valid,
  input wire logic [12:0] conv_data,
  input wire logic [12:0] critical_limit,
  input wire logic [12:0] upper_limit,
  input wire logic [12:0] lower_limit
);

  // ----------------------------------------------------------------
  // word source
  // ----------------------------------------------------------------
  tsr_word_if wif ();

  tsr_sample u_sample (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .critical_limit(critical_limit),
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .wif(wif)
  );

  // unknown pointers read as zero rather than aliasing
  function automatic logic [15:0] sel_word(input logic [7:0] ptr, input logic [15:0] temp);
    logic [15:0] r;
    r = 16'h0000;
    if (ptr == `TSR_PTR_TEMP) begin
      r = temp;
    end else if (ptr == `TSR_PTR_MAKER) begin
      r = MAKER_ID;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state and bus conditions
  // ----------------------------------------------------------------
  tsr_top_st_t st;
  tsr_top_st_t next_st;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = st.scl_s2 && !st.scl_d;
  assign scl_fall = !st.scl_s2 && st.scl_d;
  assign bus_start = st.scl_s2 && st.scl_d && st.sda_d && !st.sda_s2;
  assign bus_stop = st.scl_s2 && st.scl_d && !st.sda_d && st.sda_s2;

  always_comb begin
    next_st = st;
    next_st.scl_s1 = scl_in;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = sda_in;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;
    next_st.sda_out = 1'b0;
    if (bus_stop) begin
      next_st.state = TSR_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else if (bus_start) begin
      next_st.state = TSR_ADDR;
      next_st.bit_cnt = 3'h0;
      next_st.got8 = 1'b0;
      next_st.sda_oe_n = 1'b1;
    end else begin
      unique case (st.state)
        TSR_IDLE: begin
        end
        TSR_ADDR, TSR_RX_PTR: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], st.sda_s2};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7) begin
              next_st.got8 = 1'b1;
            end
          end else if (scl_fall && st.got8) begin
            next_st.got8 = 1'b0;
            if (st.state == TSR_ADDR) begin
              if (st.shift[7:1] == SLAVE_ADDR) begin
                next_st.rw = st.shift[0];
                next_st.sda_oe_n = 1'b0;
                next_st.state = TSR_ACK_ADDR;
                if (st.shift[0]) begin
                  next_st.tx_word = sel_word(st.pointer, wif.word);
                end
              end else begin
                next_st.state = TSR_IDLE;
              end
            end else begin
              next_st.pointer = st.shift;
              next_st.sda_oe_n = 1'b0;
              next_st.state = TSR_ACK_PTR;
            end
          end
        end
        TSR_ACK_ADDR: begin
          if (scl_fall) begin
            next_st.bit_cnt = 3'h0;
            if (st.rw) begin
              next_st.state = TSR_TX;
              next_st.shift = st.tx_word[15:8];
              next_st.sda_oe_n = st.tx_word[15];
              next_st.low_next = 1'b1;
            end else begin
              next_st.state = TSR_RX_PTR;
              next_st.sda_oe_n = 1'b1;
            end
          end
        end
        TSR_ACK_PTR: begin
          if (scl_fall) begin
            next_st.sda_oe_n = 1'b1;
            next_st.state = TSR_IDLE;
          end
        end
        TSR_TX: begin
          if (scl_fall) begin
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7) begin
              next_st.sda_oe_n = 1'b1;
              next_st.state = TSR_TX_ACK;
              next_st.got8 = 1'b0;
            end else begin
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.sda_oe_n = st.shift[6];
            end
          end
        end
        TSR_TX_ACK: begin
          if (scl_rise) begin
            next_st.got8 = !st.sda_s2;
          end else if (scl_fall) begin
            if (st.got8) begin
              // acked byte: send other half, same snapshot
              next_st.shift = st.low_next ? st.tx_word[7:0] : st.tx_word[15:8];
              next_st.sda_oe_n = st.low_next ? st.tx_word[7] : st.tx_word[15];
              next_st.low_next = !st.low_next;
              next_st.bit_cnt = 3'h0;
              next_st.got8 = 1'b0;
              next_st.state = TSR_TX;
            end else begin
              next_st.state = TSR_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '{state: TSR_IDLE, pointer: `TSR_PTR_RST, tx_word: `TSR_WORD_RST,
              scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
              sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
              sda_oe_n: 1'b1, default: '0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign sda_out = st.sda_out;
  assign sda_oe_n = st.sda_oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_rd_addr;
    clk_en && !bus_start && !bus_stop && st.state == TSR_ADDR && scl_fall && st.got8
      && st.shift[7:1] == SLAVE_ADDR && st.shift[0];
  endsequence

  sequence s_enter_tx;
    st.state == TSR_TX && $past(st.state) == TSR_ACK_ADDR;
  endsequence

  chk_maker_code: assert property (@(posedge sys_clk) disable iff (srst)
    s_rd_addr ##0 (st.pointer == `TSR_PTR_MAKER) |=> st.tx_word == MAKER_ID)
    else $error("maker code not loaded");
  chk_temp_snap: assert property (@(posedge sys_clk) disable iff (srst)
    s_rd_addr ##0 (st.pointer == `TSR_PTR_TEMP) |=> st.tx_word == $past(wif.word))
    else $error("temperature snapshot wrong");
  chk_high_first: assert property (@(posedge sys_clk) disable iff (srst)
    s_enter_tx |-> st.shift == st.tx_word[15:8] && st.bit_cnt == 3'h0)
    else $error("high byte not first");
  chk_crit_first: assert property (@(posedge sys_clk) disable iff (srst)
    s_enter_tx |-> st.sda_oe_n == st.tx_word[`TSR_BIT_CRIT])
    else $error("critical flag not first bit");
  chk_snap_stable: assert property (@(posedge sys_clk) disable iff (srst)
    st.state inside {TSR_TX, TSR_TX_ACK} && $past(st.state) inside {TSR_TX, TSR_TX_ACK}
      |-> $stable(st.tx_word))
    else $error("snapshot changed mid read");
  chk_addr_ack: assert property (@(posedge sys_clk) disable iff (srst)
    s_rd_addr |=> st.state == TSR_ACK_ADDR && !st.sda_oe_n)
    else $error("address not acknowledged");

endmodule // tsr_top
`default_nettype wire

// ---- tsr_host_model.sv ----
// Purpose: bus host model that reads device registers through the pointer
// Assumes: sda is open-drain with a pull-up, resolved by the bench
// Notes: a data bit's scl high phase lasts HALF sys_clk cycles; its scl low phase lasts HALF+2
`timescale 1ns/1ns
`default_nettype none
module tsr_host_model #(
  parameter int HALF = 8
) (
  input wire logic sys_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic host_pull,
  output logic rd_valid,
  output logic [18:0] rd_data
);
  initial begin
    scl = 1'b1;
    host_pull = 1'b0;
    rd_valid = 1'b0;
    rd_data = 19'h0_0000;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // serves first and repeated start alike
  task automatic start_cond();
    host_pull = 1'b0;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    host_pull = 1'b1;
    wait_n(HALF);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    wait_n(2);
    host_pull = 1'b1;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    host_pull = 1'b0;
    wait_n(HALF);
  endtask

  // data moves well after scl fell, so sync skew never mimics a start
  task automatic bit_io(input logic b, output logic r);
    wait_n(2);
    host_pull = !b;
    wait_n(HALF);
    scl = 1'b1;
    wait_n(HALF);
    r = sda_wire;
    scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_in, ack_out);
  endtask

  task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr);
    logic [2:0] acks;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] dummy;
    logic a_dummy;
    start_cond();
    xfer({addr, 1'b0}, 1'b1, dummy, acks[2]);
    xfer(ptr, 1'b1, dummy, acks[1]);
    // reread: high acked, low not, stop
    start_cond();
    xfer({addr, 1'b1}, 1'b1, dummy, acks[0]);
    xfer(8'hFF, 1'b0, hi, a_dummy);
    xfer(8'hFF, 1'b1, lo, a_dummy);
    stop_cond();
    rd_data = {acks, hi, lo};
    rd_valid = 1'b1;
    wait_n(1);
    rd_valid = 1'b0;
  endtask
endmodule // tsr_host_model
`default_nettype wire

// ---- tsr_top_bench.sv ----
// Purpose: self-checking bench of the temperature read-out block
// Assumes: host model drives the bus; bench drives conversions at falling edge
// Notes: results are paired with expectations through a queue
`timescale 1ns/1ns
`default_nettype none
`include "tsr_params.svh"
module tsr_top_bench;
  logic sys_clk, srst, clk_en, conv_valid, scl, host_pull, sda_out, sda_oe_n, rd_valid;
  logic [12:0] conv_data, crit, upper, lower;
  logic [18:0] rd_data;
  wire logic sda_wire;
  int n_errors, checks_done, cycles;
  integer seed;
  logic [18:0] exp_q[$];
  logic [12:0] temps [10] = '{13'h0194, 13'h0190, 13'h0500, 13'h04FC, 13'h1FC0,
                              13'h1FBC, 13'h0200, 13'h1000, 13'h0FFF, 13'h1FE8};

  assign sda_wire = !((!sda_oe_n && !sda_out) || host_pull);
  always #10 sys_clk = ~sys_clk;

  tsr_top #(.SLAVE_ADDR(7'h18), .MAKER_ID(`TSR_MAKER_ID)) tsr_top_inst (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_valid(conv_valid),
    .conv_data(conv_data), .critical_limit(crit), .upper_limit(upper),
    .lower_limit(lower));

  tsr_host_model #(.HALF(8)) tsr_host_model_inst (
    .sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .host_pull(host_pull),
    .rd_valid(rd_valid), .rd_data(rd_data));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_word(input logic [12:0] d);
    logic signed [12:0] m;
    m = {d[12:2], 2'b00};
    return {m >= $signed(crit), m > $signed(upper), m < $signed(lower), m};
  endfunction

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic load(input logic [12:0] d);
    @(negedge sys_clk);
    conv_data = d;
    conv_valid = 1'b1;
    @(negedge sys_clk);
    conv_valid = 1'b0;
  endtask

  task automatic read_temp(input logic [12:0] d);
    load(d);
    exp_q.push_back({3'b000, exp_word(d)});
    tsr_host_model_inst.read_reg(7'h18, `TSR_PTR_TEMP);
  endtask

  // ----------------------------------------------------------------
  // result watcher and hang guard
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(rd_data, ~rd_data);
      end else begin
        check(rd_data, exp_q.pop_front());
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    clk_en = 1'b1;
    conv_valid = 1'b0;
    conv_data = 13'h0000;
    crit = 13'h0500;
    upper = 13'h0190;
    lower = 13'h1FC0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    seed = 32'h218532ef;
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    exp_q.push_back({3'b000, `TSR_MAKER_ID});
    tsr_host_model_inst.read_reg(7'h18, `TSR_PTR_MAKER);
    // foreign address: no acknowledge, released line reads all ones
    exp_q.push_back(19'h7_FFFF);
    tsr_host_model_inst.read_reg(7'h19, `TSR_PTR_TEMP);
    exp_q.push_back(19'h0_0000);
    tsr_host_model_inst.read_reg(7'h18, 8'h03);
    // limit boundaries, sign edges, 32 degrees held in the high byte alone
    foreach (temps[i]) begin
      read_temp(temps[i]);
    end
    // clock enable low: this conversion must be lost, old word stays
    @(negedge sys_clk);
    clk_en = 1'b0;
    load(13'h0500);
    clk_en = 1'b1;
    exp_q.push_back({3'b000, exp_word(temps[9])});
    tsr_host_model_inst.read_reg(7'h18, `TSR_PTR_TEMP);
    repeat (8) begin
      crit = 13'($random(seed)) & 13'h1FFC;
      upper = 13'($random(seed)) & 13'h1FFC;
      lower = 13'($random(seed)) & 13'h1FFC;
      read_temp(13'($random(seed)));
    end
    // a conversion landing mid-read must not tear the word
    load(13'h0194);
    exp_q.push_back({3'b000, exp_word(13'h0194)});
    fork
      tsr_host_model_inst.read_reg(7'h18, `TSR_PTR_TEMP);
      begin
        repeat (650) @(negedge sys_clk);
        load(13'h1000);
      end
    join
    repeat (10) @(negedge sys_clk);
    test_done();
  end
endmodule // tsr_top_bench
`default_nettype wire
